//--- rtl/pbr_device.sv
// module: bridge device end, role strap, clock outputs and sideband pins
`timescale 1ns/100ps
module pbr_device #(
  parameter int unsigned CLK_HALF = pbr_pkg::CLK_HALF_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bridge_role_select,
  input wire logic need_full_perf,
  input wire logic wake_event,
  input wire logic wake_clear,
  pbr_link_if.device link,
  output logic host_role,
  output logic arbiter_enable,
  output logic bus_fast,
  output logic restart_requested,
  output logic bus_clock_rise,
  output logic wake_pending
);
  import pbr_pkg::*;

  // elaboration checks on the divider and the settle counter
  if (CLK_HALF < 1) begin : g_half_low
    $error("CLK_HALF below one");
  end
  if (CLK_HALF > 255) begin : g_half_high
    $error("CLK_HALF exceeds divider width");
  end
  if ((REF_CLK_MHZ / (2 * CLK_HALF)) < BUS_MIN_MHZ) begin : g_bus_slow
    $error("host bus clock below minimum");
  end
  if ((REF_CLK_MHZ / (2 * CLK_HALF)) > BUS_MAX_MHZ &&
      (REF_CLK_MHZ / (2 * CLK_HALF)) != BUS_FAST_MHZ) begin : g_bus_fast
    $error("host bus clock outside allowed range");
  end
  if (SYNC_STAGES != 2) begin : g_sync_depth
    $error("synchroniser depth must be two");
  end

  typedef struct packed {
    pbr_role_t role;
    logic [1:0] settle;
    logic [7:0] div_cnt;
    logic clk_out;
    logic [1:0] strap_sync;
    logic [1:0] clk_sync;
    logic clk_prev;
    logic [1:0] fast_sync;
    logic [1:0] restart_sync;
    logic clk_rise;
    logic fast;
    logic restart;
    logic wake;
    logic active;
  } pbr_dev_state_t;

  localparam pbr_dev_state_t ST_RESET = '{
    role: PBR_ROLE_WAIT,
    settle: 2'h0,
    div_cnt: 8'h00,
    clk_out: 1'h0,
    strap_sync: {2{RESET_ROLE}},
    clk_sync: 2'h0,
    clk_prev: 1'h0,
    fast_sync: 2'h0,
    restart_sync: {2{RESET_LEVEL_N}},
    clk_rise: 1'h0,
    fast: 1'h0,
    restart: 1'h0,
    wake: 1'h0,
    active: 1'h0
  };

  // shift one pin sample into a two stage synchroniser
  function automatic logic [1:0] sync_push(
    input logic [1:0] stages,
    input logic pin
  );
    return {stages[0], pin};
  endfunction : sync_push

  // rising edge of the synchronised bus clock
  function automatic logic bus_rise(
    input logic cur,
    input logic prev
  );
    return cur & ~prev;
  endfunction : bus_rise

  function automatic logic is_host(
    input pbr_role_t role
  );
    return role == PBR_ROLE_HOST;
  endfunction : is_host

  // wake flag: a new event wins over a clear in the same cycle
  function automatic logic wake_next(
    input logic cur,
    input logic set_ev,
    input logic clr
  );
    logic nxt;
    nxt = cur;
    if (set_ev) begin
      nxt = 1'h1;
    end else if (clr) begin
      nxt = 1'h0;
    end
    return nxt;
  endfunction : wake_next

  pbr_dev_state_t st_r;
  pbr_dev_state_t st_nxt;
  logic [2:0] clk_fan;
  logic bus_rise_now;

  assign bus_rise_now = bus_rise(st_r.clk_sync[1], st_r.clk_prev);

  always_comb begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.strap_sync = sync_push(st_r.strap_sync, bridge_role_select);
    st_nxt.clk_sync = sync_push(st_r.clk_sync, link.bus_clock_in);
    st_nxt.fast_sync = sync_push(st_r.fast_sync, link.fast_bus_indicator);
    st_nxt.restart_sync = sync_push(st_r.restart_sync, link.clock_restart_request_n);
    st_nxt.clk_prev = st_r.clk_sync[1];

    // role taken once the strap has passed the synchroniser, held until next reset
    case (st_r.role)
      PBR_ROLE_WAIT: begin
        if (st_r.settle == 2'(SYNC_STAGES)) begin
          st_nxt.role = st_r.strap_sync[1] ? PBR_ROLE_HOST : PBR_ROLE_GUEST;
        end else begin
          st_nxt.settle = st_r.settle + 2'h1;
        end
      end
      PBR_ROLE_HOST: begin
        st_nxt.role = PBR_ROLE_HOST;
      end
      PBR_ROLE_GUEST: begin
        st_nxt.role = PBR_ROLE_GUEST;
      end
      default: begin
        st_nxt.role = PBR_ROLE_WAIT;
      end
    endcase

    // bus clock divider runs only in host role
    if (is_host(st_r.role)) begin
      if (st_r.div_cnt == 8'(CLK_HALF - 1)) begin
        st_nxt.div_cnt = 8'h00;
        st_nxt.clk_out = ~st_r.clk_out;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      end
    end else begin
      st_nxt.div_cnt = 8'h00;
      st_nxt.clk_out = 1'h0;
    end

    // bus side values are taken on a bus clock rise only
    st_nxt.clk_rise = bus_rise_now;
    if (bus_rise_now) begin
      st_nxt.fast = st_r.fast_sync[1];
      st_nxt.restart = ~st_r.restart_sync[1];
      st_nxt.active = need_full_perf;
    end

    st_nxt.wake = wake_next(st_r.wake, wake_event, wake_clear);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // the three bus clock outputs carry one divider output
  for (genvar i = 0; i < 3; i++) begin : g_clk_fan
    assign clk_fan[i] = st_r.clk_out;
  end

  assign host_role = is_host(st_r.role);
  assign arbiter_enable = is_host(st_r.role);
  assign link.bus_clock_out_main = clk_fan[0];
  assign link.bus_clock_out_b = clk_fan[1];
  assign link.bus_clock_out_c = clk_fan[2];
  assign link.dev_active_o = 1'h0;
  assign link.dev_active_oe_n = ~st_r.active;
  assign link.dev_wake_o = 1'h0;
  assign link.dev_wake_oe_n = ~st_r.wake;
  assign bus_fast = st_r.fast;
  assign restart_requested = st_r.restart;
  assign bus_clock_rise = st_r.clk_rise;
  assign wake_pending = st_r.wake;
endmodule : pbr_device

//--- rtl/pbr_pkg.sv
// package: constants and types shared by both ends of the bridge sideband link
package pbr_pkg;
  localparam int unsigned REF_CLK_MHZ = 40;
  localparam int unsigned BUS_MIN_MHZ = 20;
  localparam int unsigned BUS_MAX_MHZ = 33;
  localparam int unsigned BUS_FAST_MHZ = 66;
  // clock output divider half period in ref_clk cycles (link clock made by host end)
  localparam int unsigned CLK_HALF_DEFAULT = 1;
  localparam logic RESET_ROLE = 1'h0;
  localparam logic RESET_LEVEL_N = 1'h1;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    PBR_ROLE_WAIT = 2'h0,
    PBR_ROLE_HOST = 2'h1,
    PBR_ROLE_GUEST = 2'h3
  } pbr_role_t;
endpackage : pbr_pkg

//--- rtl/pbr_link_if.sv
// interface: sideband pins between bridge device and far agent
`timescale 1ns/100ps
interface pbr_link_if;
  logic bus_clock_out_main;
  logic bus_clock_out_b;
  logic bus_clock_out_c;
  logic bus_clock_in;
  logic fast_bus_indicator;
  logic clock_restart_request_n_o;
  logic clock_restart_request_n_oe_n;
  logic dev_active_o;
  logic dev_active_oe_n;
  logic far_active_o;
  logic far_active_oe_n;
  logic dev_wake_o;
  logic dev_wake_oe_n;
  // open-drain wires resolved from enables, pulled high when released
  logic clock_restart_request_n;
  logic mini_card_active_n;
  logic wake_event_out_n;
  assign clock_restart_request_n = clock_restart_request_n_oe_n ? 1'b1 : clock_restart_request_n_o;
  assign mini_card_active_n = (dev_active_oe_n ? 1'b1 : dev_active_o)
                            & (far_active_oe_n ? 1'b1 : far_active_o);
  assign wake_event_out_n = dev_wake_oe_n ? 1'b1 : dev_wake_o;
  modport device (
    output bus_clock_out_main, bus_clock_out_b, bus_clock_out_c,
    input bus_clock_in, fast_bus_indicator, clock_restart_request_n,
    input mini_card_active_n,
    output dev_active_o, dev_active_oe_n, dev_wake_o, dev_wake_oe_n
  );
  modport agent (
    input bus_clock_out_main, bus_clock_out_b, bus_clock_out_c,
    output bus_clock_in, fast_bus_indicator,
    output clock_restart_request_n_o, clock_restart_request_n_oe_n,
    output far_active_o, far_active_oe_n,
    input mini_card_active_n, wake_event_out_n
  );
endinterface : pbr_link_if

//--- rtl/pbr_agent.sv
// module: far agent end, loops or supplies bus clock and drives sideband lines
`timescale 1ns/100ps
module pbr_agent #(
  parameter int unsigned CLK_HALF = pbr_pkg::CLK_HALF_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic supply_clock,
  input wire logic fast_segment,
  input wire logic request_restart,
  input wire logic agent_active,
  pbr_link_if.agent link,
  output logic wake_seen,
  output logic perf_requested
);
  import pbr_pkg::*;

  if (CLK_HALF < 1 || CLK_HALF > 255) begin : g_half_range
    $error("CLK_HALF out of range");
  end
  if ((REF_CLK_MHZ / (2 * CLK_HALF)) < BUS_MIN_MHZ) begin : g_bus_slow
    $error("bus clock below minimum");
  end
  if ((REF_CLK_MHZ / (2 * CLK_HALF)) > BUS_MAX_MHZ &&
      (REF_CLK_MHZ / (2 * CLK_HALF)) != BUS_FAST_MHZ) begin : g_bus_fast
    $error("bus clock outside allowed range");
  end

  typedef struct packed {
    logic [7:0] div_cnt;
    logic clk_out;
    logic [1:0] wake_sync;
    logic [1:0] act_sync;
    logic wake;
    logic act;
  } pbr_agt_state_t;

  pbr_agt_state_t st_r;
  pbr_agt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wake_sync = {st_r.wake_sync[0], link.wake_event_out_n};
    st_nxt.act_sync = {st_r.act_sync[0], link.mini_card_active_n};
    st_nxt.wake = ~st_r.wake_sync[1];
    st_nxt.act = ~st_r.act_sync[1];
    if (st_r.div_cnt == 8'(CLK_HALF - 1)) begin
      st_nxt.div_cnt = 8'h00;
      st_nxt.clk_out = ~st_r.clk_out;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{div_cnt: 8'h00, clk_out: 1'h0, wake_sync: {2{RESET_LEVEL_N}},
                act_sync: {2{RESET_LEVEL_N}}, wake: 1'h0, act: 1'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // supply_clock low means loop back the device's own clock output
  assign link.bus_clock_in = supply_clock ? st_r.clk_out : link.bus_clock_out_main;
  assign link.fast_bus_indicator = fast_segment;
  assign link.clock_restart_request_n_o = 1'b0;
  assign link.clock_restart_request_n_oe_n = ~request_restart;
  assign link.far_active_o = 1'b0;
  assign link.far_active_oe_n = ~agent_active;
  assign wake_seen = st_r.wake;
  assign perf_requested = st_r.act;
endmodule : pbr_agent

//--- tb/pbr_monitor.sv
// checker: pin behaviour of the device end on the sideband link
`timescale 1ns/100ps
module pbr_monitor (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bus_clock_out_main,
  input wire logic bus_clock_out_b,
  input wire logic bus_clock_out_c,
  input wire logic dev_active_o,
  input wire logic dev_active_oe_n,
  input wire logic dev_wake_o,
  input wire logic dev_wake_oe_n,
  input wire logic mini_card_active_n,
  input wire logic wake_event_out_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_CLK_B: assert property (
    bus_clock_out_b == bus_clock_out_main) else $error("clock b off main");
  AST_CLK_C: assert property (
    bus_clock_out_c == bus_clock_out_main) else $error("clock c off main");
  // divider half period of one cycle in this bench
  AST_CLK_HIGH: assert property (
    $rose(bus_clock_out_main) |=> $fell(bus_clock_out_main)) else $error("clock high too long");
  AST_CLK_LOW: assert property (
    $fell(bus_clock_out_main) |=> $rose(bus_clock_out_main)) else $error("clock low too long");
  AST_WAKE_DRV: assert property (
    !dev_wake_oe_n |-> !dev_wake_o) else $error("wake driven high");
  AST_WAKE_WIRE: assert property (
    $fell(dev_wake_oe_n) |-> !wake_event_out_n ##1 !wake_event_out_n) else $error("wake wire high");
  AST_ACT_DRV: assert property (
    !dev_active_oe_n |-> !dev_active_o) else $error("activity driven high");
  AST_ACT_WIRE: assert property (
    !dev_active_oe_n |-> !mini_card_active_n) else $error("activity wire high");
endmodule : pbr_monitor

//--- tb/testbench.sv
// testbench: both bridge ends joined over the sideband link
`timescale 1ns/100ps
module testbench;
  import pbr_pkg::*;
  logic ref_clk, arst_n, strap, perf, wake, wclr, supply, fast, rreq, act;
  logic host_role, arb_en, bus_fast, rst_req, clk_rise, wake_pend, wake_seen, perf_req;
  int error_cnt = 0;
  int num_checks = 0;
  pbr_link_if link ();
  pbr_device #(.CLK_HALF(1)) pbr_device_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .bridge_role_select(strap), .need_full_perf(perf), .wake_event(wake), .wake_clear(wclr),
    .link(link), .host_role(host_role), .arbiter_enable(arb_en), .bus_fast(bus_fast),
    .restart_requested(rst_req), .bus_clock_rise(clk_rise), .wake_pending(wake_pend));
  pbr_agent #(.CLK_HALF(1)) pbr_agent_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .supply_clock(supply), .fast_segment(fast), .request_restart(rreq), .agent_active(act),
    .link(link), .wake_seen(wake_seen), .perf_requested(perf_req));
  pbr_monitor pbr_monitor_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .bus_clock_out_main(link.bus_clock_out_main), .bus_clock_out_b(link.bus_clock_out_b),
    .bus_clock_out_c(link.bus_clock_out_c), .dev_active_o(link.dev_active_o),
    .dev_active_oe_n(link.dev_active_oe_n), .dev_wake_o(link.dev_wake_o),
    .dev_wake_oe_n(link.dev_wake_oe_n), .mini_card_active_n(link.mini_card_active_n),
    .wake_event_out_n(link.wake_event_out_n));
  wire logic [8:0] obs = {link.mini_card_active_n, link.wake_event_out_n, perf_req,
    wake_seen, wake_pend, rst_req, bus_fast, arb_en, host_role};
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic await(input int k, input logic exp);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (obs[k] !== exp && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(obs[k], exp);
    if (obs[k] !== exp) results();
  endtask : await
  task automatic drive(input logic [5:0] v);
    @(posedge ref_clk);
    {perf, wake, wclr, fast, rreq, act} <= v;
  endtask : drive
  task automatic start(input logic role, input logic sup);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    strap <= role;
    supply <= sup;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : start
  task automatic count_edges(output int main_n, output int rise_n);
    main_n = 0;
    rise_n = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      main_n += link.bus_clock_out_main;
      rise_n += clk_rise;
    end
  endtask : count_edges
  initial begin
    int m, r;
    arst_n = 1'b0;
    strap = 1'b0;
    supply = 1'b0;
    {perf, wake, wclr, fast, rreq, act} = 6'h00;
    start(1'b1, 1'b0);
    check(host_role, 1'b1);
    check(arb_en, 1'b1);
    count_edges(m, r);
    check(m > 10, 1'b1);
    check(r > 5, 1'b1);
    @(posedge ref_clk);
    strap <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check(host_role, 1'b1);
    $display("test host role done");
    start(1'b0, 1'b1);
    check(host_role, 1'b0);
    check(arb_en, 1'b0);
    count_edges(m, r);
    check(m == 0, 1'b1);
    check(r > 5, 1'b1);
    drive(6'h04);
    await(2, 1'b1);
    drive(6'h02);
    await(3, 1'b1);
    drive(6'h20);
    await(6, 1'b1);
    drive(6'h00);
    await(6, 1'b0);
    drive(6'h01);
    await(8, 1'b0);
    drive(6'h10);
    drive(6'h18);
    await(7, 1'b0);
    await(5, 1'b1);
    check(wake_pend, 1'b1);
    drive(6'h08);
    await(4, 1'b0);
    await(7, 1'b1);
    $display("test guest role done");
    results();
  end
endmodule : testbench
